/* rtl/dspc_pkg.sv */
// shared constants and types for the diagnostic switch press classifier
package dspc_pkg;
    // clock and millisecond time base
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    // press timing, all in milliseconds
    localparam int MSW = 15;
    localparam logic [14:0] SHORT_MIN_MS = 15'h003c;   // 60 ms
    localparam logic [14:0] LONG_MIN_MS = 15'h03e8;    // 1 s
    localparam logic [14:0] LOCK_MIN_MS = 15'h4e2a;    // 20.01 s
    localparam logic [14:0] DEB_MS = 15'h0004;
    // presentation and indicator timing, in milliseconds
    localparam logic [14:0] SCREEN_MS = 15'h07d0;
    localparam logic [14:0] BLINK_MS = 15'h0032;
    // diagnostic area byte map
    localparam logic [9:0] SUMMARY_LAST = 10'h003;
    localparam logic [9:0] DETAIL_FIRST = 10'h004;
    localparam logic [9:0] DETAIL_LAST = 10'h230;      // byte 560
    localparam int MODDIAG_BIT = 4;
    // display field widths
    localparam int SRCW = 4;
    localparam int IDXW = 6;

    typedef enum logic [2:0] {
        DSPC_IDLE,
        DSPC_TAG,
        DSPC_DIAG,
        DSPC_NODIAG,
        DSPC_MENU
    } dspc_mode_type;

    typedef struct packed {
        logic ignored;
        logic short_touch;
        logic long_touch;
        logic locked;
    } dspc_press_type;

    typedef struct packed {
        dspc_mode_type mode;
        logic [SRCW-1:0] source;
        logic [IDXW-1:0] index;
    } dspc_disp_type;
endpackage : dspc_pkg

/* rtl/dspc_press_timer.sv */
// switch synchroniser, debouncer, millisecond base and press classifier
`timescale 1ns/10ps
module dspc_press_timer
    import dspc_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // switch pin, low while pressed
    input wire logic switch_n,
    // results
    output logic ms_tick,
    output dspc_press_type press
);
    localparam int PW = $clog2(MS_CYCLES_P + 1);

    logic sync1_q, sync2_q;
    logic [PW-1:0] pre_q;
    logic tick_q;
    logic [MSW-1:0] deb_q;
    logic stable_q;
    logic [MSW-1:0] held_q;
    dspc_press_type press_q;

    wire logic pressed_raw = ~sync2_q;
    wire logic pre_end = (pre_q == PW'(MS_CYCLES_P - 1));
    wire logic deb_done = tick_q && (deb_q == DEB_MS - 15'h0001);
    wire logic release_w = deb_done && stable_q && !pressed_raw;

    // two-stage pin synchroniser
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end
        else
        begin
            sync1_q <= switch_n;
            sync2_q <= sync1_q;
        end
    end

    // millisecond prescaler
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pre_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            pre_q <= pre_end ? '0 : pre_q + PW'(1);
            tick_q <= pre_end;
        end
    end

    // debounce: new level must hold for DEB_MS ticks
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            deb_q <= '0;
            stable_q <= 1'b0;
        end
        else if (pressed_raw == stable_q)
            deb_q <= '0;
        else if (deb_done)
        begin
            deb_q <= '0;
            stable_q <= pressed_raw;
        end
        else if (tick_q)
            deb_q <= deb_q + 15'h0001;
    end

    // press duration, saturating at the locked threshold
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            held_q <= '0;
        else if (!stable_q)
            held_q <= '0;
        else if (tick_q && held_q != LOCK_MIN_MS)
            held_q <= held_q + 15'h0001;
    end

    // classification, acted on at release except the locked level
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            press_q <= '0;
        else
        begin
            press_q.ignored <= release_w && held_q < SHORT_MIN_MS;
            press_q.short_touch <= release_w && held_q >= SHORT_MIN_MS
                && held_q < LONG_MIN_MS;
            press_q.long_touch <= release_w && held_q >= LONG_MIN_MS
                && held_q < LOCK_MIN_MS;
            press_q.locked <= stable_q && held_q == LOCK_MIN_MS;
        end
    end

    assign ms_tick = tick_q;
    assign press = press_q;
endmodule : dspc_press_timer

/* rtl/dspc_diag_switch_ctrl.sv */
// diagnostic switch controller: presentation, bus modules, leds, diag map
`timescale 1ns/10ps
module dspc_diag_switch_ctrl
    import dspc_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES,
    parameter int N_MOD = 8,
    parameter int N_DIAG = 32,
    parameter int N_PORT = 2
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // front panel switch pin, low while pressed
    input wire logic diag_switch_n,
    // bus module events, same clock domain
    input wire logic [N_MOD-1:0] mod_short_press,
    input wire logic [N_MOD-1:0] mod_stuck,
    input wire logic [N_MOD-1:0] mod_hot_swap,
    input wire logic [N_MOD-1:0] mod_diag_active,
    // active diagnostic masks, own and per module
    input wire logic [N_DIAG-1:0] own_diag_mask,
    input wire logic [N_MOD*N_DIAG-1:0] mod_diag_mask,
    // display control
    output dspc_disp_type disp,
    output logic own_switch_locked,
    output logic any_module_flagged,
    // ethernet port status and leds
    input wire logic [N_PORT-1:0] link_up,
    input wire logic [N_PORT-1:0] link_100,
    input wire logic [N_PORT-1:0] frame_evt,
    output logic [N_PORT-1:0] led_yellow,
    output logic [N_PORT-1:0] led_green,
    // diagnostic area read port
    input wire logic [31:0] summary_in,
    input wire logic [9:0] diag_rd_addr,
    input wire logic [7:0] detail_rd_data,
    output logic [7:0] diag_rd_data
);
    logic ms_tick;
    dspc_press_type press;

    dspc_press_timer #(
        .MS_CYCLES_P(MS_CYCLES_P)
    ) u_timer (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .switch_n(diag_switch_n),
        .ms_tick(ms_tick),
        .press(press)
    );

    // first active diagnostic at or above a start index
    function automatic logic [IDXW:0] next_diag(input logic [N_DIAG-1:0] m,
                                                input int from);
        logic [IDXW:0] r;
        r = '0;
        for (int i = N_DIAG - 1; i >= 0; i--)
            if (m[i] && i >= from)
                r = {1'b1, IDXW'(i)};
        return r;
    endfunction : next_diag

    // lowest requesting module, returned as source number (1 based)
    function automatic logic [SRCW-1:0] first_mod(input logic [N_MOD-1:0] m);
        logic [SRCW-1:0] r;
        r = '0;
        for (int i = N_MOD - 1; i >= 0; i--)
            if (m[i])
                r = SRCW'(i + 1);
        return r;
    endfunction : first_mod

    dspc_mode_type mode_q, mode_d;
    logic [SRCW-1:0] src_q, src_d;
    logic [IDXW-1:0] idx_q, idx_d;
    logic pass_q, pass_d;
    logic [MSW-1:0] dwell_q;
    logic [N_MOD-1:0] stuck_q;
    logic any_q;
    logic locked_q;
    logic [7:0] rd_q;

    // diagnostic mask of the source being shown
    wire logic [N_DIAG-1:0] cur_mask = (src_q == '0) ? own_diag_mask :
        mod_diag_mask[(int'(src_q) - 1) * N_DIAG +: N_DIAG];
    wire logic running = mode_q == DSPC_TAG || mode_q == DSPC_DIAG
        || mode_q == DSPC_NODIAG;
    wire logic [N_MOD-1:0] mod_req = mod_short_press & ~stuck_q;
    wire logic any_mod_press = |mod_short_press;
    wire logic screen_end = ms_tick && dwell_q == SCREEN_MS - 15'h0001;
    wire logic [IDXW:0] from_tag = next_diag(cur_mask, 0);
    wire logic [IDXW:0] from_idx = next_diag(cur_mask, int'(idx_q) + 1);

    // presentation sequencer
    always_comb
    begin
        mode_d = mode_q;
        src_d = src_q;
        idx_d = idx_q;
        pass_d = pass_q;
        if (press.long_touch)
            mode_d = DSPC_MENU;
        else if (running && (press.short_touch || any_mod_press))
            mode_d = DSPC_IDLE;
        else if (mode_q == DSPC_MENU && press.short_touch)
            mode_d = DSPC_IDLE;
        else if (mode_q == DSPC_IDLE && press.short_touch)
        begin
            mode_d = DSPC_TAG;
            src_d = '0;
            pass_d = 1'b0;
        end
        else if (mode_q == DSPC_IDLE && |mod_req)
        begin
            mode_d = DSPC_TAG;
            src_d = first_mod(mod_req);
            pass_d = 1'b0;
        end
        else if (running && screen_end)
        begin
            case (mode_q)
                DSPC_TAG:
                begin
                    mode_d = from_tag[IDXW] ? DSPC_DIAG : DSPC_NODIAG;
                    idx_d = from_tag[IDXW-1:0];
                end
                DSPC_DIAG:
                begin
                    if (from_idx[IDXW])
                        idx_d = from_idx[IDXW-1:0];
                    else
                    begin
                        mode_d = pass_q ? DSPC_IDLE : DSPC_TAG;
                        pass_d = 1'b1;
                    end
                end
                default:
                begin
                    mode_d = pass_q ? DSPC_IDLE : DSPC_TAG;
                    pass_d = 1'b1;
                end
            endcase
        end
    end

    // sequencer state and screen dwell timer
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_q <= DSPC_IDLE;
            src_q <= '0;
            idx_q <= '0;
            pass_q <= 1'b0;
            dwell_q <= '0;
        end
        else
        begin
            mode_q <= mode_d;
            src_q <= src_d;
            idx_q <= idx_d;
            pass_q <= pass_d;
            if (mode_d != mode_q || idx_d != idx_q || screen_end)
                dwell_q <= '0;
            else if (ms_tick)
                dwell_q <= dwell_q + 15'h0001;
        end
    end

    // stuck module latch, set wins over hot swap clear
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stuck_q <= '0;
            any_q <= 1'b0;
            locked_q <= 1'b0;
        end
        else
        begin
            stuck_q <= mod_stuck | (stuck_q & ~mod_hot_swap);
            any_q <= |(stuck_q | mod_diag_active);
            locked_q <= press.locked;
        end
    end

    // port leds, one generated set per port
    for (genvar p = 0; p < N_PORT; p++)
    begin : g_port
        logic [1:0] lsync_q;
        logic [1:0] ssync_q;
        logic [MSW-1:0] blink_q;
        logic yel_q, grn_q;
        wire logic blink_off = blink_q > BLINK_MS;

        always_ff @(posedge ref_clk or negedge resetn)
        begin
            if (!resetn)
            begin
                lsync_q <= '0;
                ssync_q <= '0;
                blink_q <= '0;
                yel_q <= 1'b0;
                grn_q <= 1'b0;
            end
            else
            begin
                lsync_q <= {lsync_q[0], link_up[p]};
                ssync_q <= {ssync_q[0], link_100[p]};
                if (blink_q != '0)
                    blink_q <= ms_tick ? blink_q - 15'h0001 : blink_q;
                else if (frame_evt[p] && lsync_q[1])
                    blink_q <= {BLINK_MS[13:0], 1'b0};
                yel_q <= lsync_q[1] && !blink_off;
                grn_q <= lsync_q[1] && ssync_q[1];
            end
        end

        assign led_yellow[p] = yel_q;
        assign led_green[p] = grn_q;
    end

    // diagnostic area read mux with module flag merged into byte 0
    wire logic [31:0] summary_w = {summary_in[31:MODDIAG_BIT+1], any_q,
        summary_in[MODDIAG_BIT-1:0]};
    wire logic [7:0] sum_byte = summary_w[diag_rd_addr[1:0]*8 +: 8];
    wire logic in_detail = diag_rd_addr >= DETAIL_FIRST
        && diag_rd_addr <= DETAIL_LAST;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rd_q <= '0;
        else if (diag_rd_addr <= SUMMARY_LAST)
            rd_q <= sum_byte;
        else
            rd_q <= in_detail ? detail_rd_data : 8'h00;
    end

    assign disp = '{mode: mode_q, source: src_q, index: idx_q};
    assign own_switch_locked = locked_q;
    assign any_module_flagged = any_q;
    assign diag_rd_data = rd_q;
endmodule : dspc_diag_switch_ctrl

/* bench/dspc_diag_switch_ctrl_properties.sv */
// port checker for the diagnostic switch controller
`timescale 1ns/10ps
module dspc_diag_switch_ctrl_properties
    import dspc_pkg::*;
#(
    parameter int N_MOD = 8,
    parameter int N_PORT = 2
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // module events
    input wire logic [N_MOD-1:0] mod_short_press,
    input wire logic [N_MOD-1:0] mod_stuck,
    input wire logic [N_MOD-1:0] mod_hot_swap,
    // display and flags
    input wire dspc_disp_type disp,
    input wire logic any_module_flagged,
    // port leds
    input wire logic [N_PORT-1:0] link_up,
    input wire logic [N_PORT-1:0] link_100,
    input wire logic [N_PORT-1:0] led_green,
    // diagnostic area read
    input wire logic [31:0] summary_in,
    input wire logic [9:0] diag_rd_addr,
    input wire logic [7:0] detail_rd_data,
    input wire logic [7:0] diag_rd_data
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // stuck report that no swap follows
    sequence s_stuck;
        (mod_stuck != '0) ##1 (mod_hot_swap == '0);
    endsequence
    // link pins steady long enough to cross the synchroniser
    sequence s_no_link;
        (!link_up[0]) [*4];
    endsequence
    sequence s_link_100;
        (link_up[0] && link_100[0]) [*4];
    endsequence
    sequence s_link_10;
        (link_up[0] && !link_100[0]) [*4];
    endsequence
    // detail bytes pass through, one cycle late
    AST_DETAIL_BYTES: assert property (
        diag_rd_addr >= DETAIL_FIRST && diag_rd_addr <= DETAIL_LAST
        |=> diag_rd_data == $past(detail_rd_data))
        else $error("detail byte not passed through");
    AST_BEYOND_MAP: assert property (
        diag_rd_addr > DETAIL_LAST |=> diag_rd_data == 8'h00)
        else $error("address past the map not zero");
    AST_SUMMARY_LOW: assert property (
        diag_rd_addr == 10'h000
        |=> diag_rd_data[3:0] == $past(summary_in[3:0]))
        else $error("summary byte zero low bits wrong");
    AST_MODULE_BIT: assert property (
        (diag_rd_addr == 10'h000 && any_module_flagged) ##1 any_module_flagged
        |-> diag_rd_data[MODDIAG_BIT])
        else $error("module diagnostic bit not set");
    AST_STUCK_FLAG: assert property (
        s_stuck |=> any_module_flagged)
        else $error("stuck module not flagged");
    AST_MOD_START: assert property (
        disp.mode == DSPC_IDLE && mod_short_press != '0 &&
        !any_module_flagged && $past(mod_stuck) == '0
        |=> disp.mode == DSPC_TAG)
        else $error("module press did not start display");
    AST_MOD_ABORT: assert property (
        disp.mode inside {DSPC_TAG, DSPC_DIAG, DSPC_NODIAG} &&
        mod_short_press != '0 |=> disp.mode == DSPC_IDLE)
        else $error("module press did not end sequence");
    AST_LED_NO_LINK: assert property (
        s_no_link |-> !led_green[0])
        else $error("green lit without link");
    AST_LED_100: assert property (
        s_link_100 |-> led_green[0])
        else $error("green dark on fast link");
    AST_LED_10: assert property (
        s_link_10 |-> !led_green[0])
        else $error("green lit on slow link");
endmodule : dspc_diag_switch_ctrl_properties

bind dspc_diag_switch_ctrl dspc_diag_switch_ctrl_properties
    #(.N_MOD(N_MOD), .N_PORT(N_PORT)) u_props (
    .ref_clk(ref_clk), .resetn(resetn), .mod_short_press(mod_short_press),
    .mod_stuck(mod_stuck), .mod_hot_swap(mod_hot_swap), .disp(disp),
    .any_module_flagged(any_module_flagged), .link_up(link_up),
    .link_100(link_100), .led_green(led_green), .summary_in(summary_in),
    .diag_rd_addr(diag_rd_addr), .detail_rd_data(detail_rd_data),
    .diag_rd_data(diag_rd_data));

/* bench/dspc_switch_model.sv */
// operator stand-in: front panel switch and module hot swap
`timescale 1ns/10ps
module dspc_switch_model
    import dspc_pkg::*;
#(
    parameter int MS_CYCLES_P = 20,
    parameter int N_MOD = 8
)
(
    // clock
    input wire logic ref_clk,
    // switch pin with pull-up, low while pressed
    output logic diag_switch_n,
    // hot swap pulses
    output logic [N_MOD-1:0] mod_hot_swap
);
    // idle levels
    initial
    begin
        diag_switch_n = 1'b1;
        mod_hot_swap = '0;
    end
    // hold the switch for whole milliseconds
    task automatic press_ms(input int ms);
        @(negedge ref_clk);
        diag_switch_n = 1'b0;
        repeat (ms * MS_CYCLES_P) @(negedge ref_clk);
        diag_switch_n = 1'b1; // pull-up level
    endtask : press_ms
    // swapping the module is the only clear of its stuck report
    task automatic hot_swap(input int k);
        @(negedge ref_clk);
        mod_hot_swap[k] = 1'b1;
        @(negedge ref_clk);
        mod_hot_swap[k] = 1'b0;
    endtask : hot_swap
endmodule : dspc_switch_model

/* bench/dspc_diag_switch_ctrl_tb.sv */
// self-checking bench for the diagnostic switch controller
`timescale 1ns/10ps
module dspc_diag_switch_ctrl_tb
    import dspc_pkg::*;
;
    localparam int MSC = 5;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic diag_switch_n, own_lock, flagged;
    logic [7:0] mod_short_press = '0, mod_stuck = '0, hot;
    logic [7:0] mod_diag_active = '0;
    logic [31:0] own_diag_mask = 32'h0000_0120;
    logic [255:0] mod_diag_mask = '0;
    logic [1:0] link_up = '0, link_100 = '0, frame_evt = '0, led_y, led_g;
    logic [31:0] summary_in = 32'h4433_222f;
    logic [9:0] diag_rd_addr = '0;
    logic [7:0] detail_rd_data = 8'h5a, diag_rd_data;
    dspc_disp_type disp;
    int fails = 0;
    int checks_done = 0;

    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    // design and operator model
    dspc_diag_switch_ctrl #(.MS_CYCLES_P(MSC)) DUT (
        .ref_clk(ref_clk), .resetn(resetn), .diag_switch_n(diag_switch_n),
        .mod_short_press(mod_short_press), .mod_stuck(mod_stuck),
        .mod_hot_swap(hot), .mod_diag_active(mod_diag_active),
        .own_diag_mask(own_diag_mask), .mod_diag_mask(mod_diag_mask),
        .disp(disp), .own_switch_locked(own_lock),
        .any_module_flagged(flagged), .link_up(link_up),
        .link_100(link_100), .frame_evt(frame_evt), .led_yellow(led_y),
        .led_green(led_g), .summary_in(summary_in),
        .diag_rd_addr(diag_rd_addr), .detail_rd_data(detail_rd_data),
        .diag_rd_data(diag_rd_data));
    dspc_switch_model #(.MS_CYCLES_P(MSC)) SW (
        .ref_clk(ref_clk), .diag_switch_n(diag_switch_n), .mod_hot_swap(hot));

    // verdict and end of run
    task automatic close_out;
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    // compare a field value
    task automatic chk_bits(input string what, input logic [15:0] exp,
                            input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_bits
    // compare the display mode
    task automatic chk_mode(input dspc_mode_type exp);
        checks_done++;
        if (disp.mode !== exp)
        begin
            fails++;
            $display("ERROR disp.mode expected %s seen %s", exp.name(),
                     disp.mode.name());
        end
    endtask : chk_mode
    // bounded wait for a display mode
    task automatic wait_mode(input dspc_mode_type exp, input int ms);
        int n = 0;
        while (disp.mode !== exp && n < ms * MSC)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk_mode(exp);
        if (disp.mode !== exp)
            close_out();
    endtask : wait_mode
    // one cycle pulse on one bit
    task automatic pulse(ref logic [7:0] v, input int k);
        @(negedge ref_clk);
        v[k] = 1'b1;
        @(negedge ref_clk);
        v[k] = 1'b0;
    endtask : pulse
    // read one diagnostic byte
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        diag_rd_addr = a;
        @(negedge ref_clk);
        chk_bits("diag_rd_data", {8'h00, exp}, {8'h00, diag_rd_data});
    endtask : rd_chk

    // press too short to count
    task automatic t_ignore;
        SW.press_ms(55);
        repeat (10 * MSC) @(negedge ref_clk);
        chk_mode(DSPC_IDLE);
    endtask : t_ignore
    // short touch, tag then lowest diagnostic, own touch ends it
    task automatic t_short;
        SW.press_ms(100);
        wait_mode(DSPC_TAG, 10);
        chk_bits("disp.source", 16'h0, {12'h0, disp.source});
        wait_mode(DSPC_DIAG, 2100);
        chk_bits("disp.index", 16'h5, {10'h0, disp.index});
        SW.press_ms(100);
        wait_mode(DSPC_IDLE, 10);
    endtask : t_short
    // long touch opens the menu, short touch leaves it
    task automatic t_long;
        SW.press_ms(1100);
        wait_mode(DSPC_MENU, 10);
        chk_bits("own_lock", 16'h0, {15'h0, own_lock});
        SW.press_ms(100);
        wait_mode(DSPC_IDLE, 10);
    endtask : t_long
    // module press shows that module, second module press ends it
    task automatic t_module;
        pulse(mod_short_press, 2);
        wait_mode(DSPC_TAG, 1);
        chk_bits("disp.source", 16'h3, {12'h0, disp.source});
        pulse(mod_short_press, 5);
        wait_mode(DSPC_IDLE, 1);
    endtask : t_module
    // module with nothing active: no-diag screen, whole run given twice
    task automatic t_twice;
        pulse(mod_short_press, 4);
        wait_mode(DSPC_TAG, 1);
        chk_bits("disp.source", 16'h5, {12'h0, disp.source});
        wait_mode(DSPC_NODIAG, 2100);
        wait_mode(DSPC_TAG, 2100);
        wait_mode(DSPC_NODIAG, 2100);
        wait_mode(DSPC_IDLE, 2100);
    endtask : t_twice
    // stuck module: flagged, ignored, cleared by hot swap
    task automatic t_stuck;
        pulse(mod_stuck, 1);
        repeat (3) @(negedge ref_clk);
        chk_bits("flagged", 16'h1, {15'h0, flagged});
        rd_chk(10'h000, 8'h3f);
        pulse(mod_short_press, 1);
        repeat (3) @(negedge ref_clk);
        chk_mode(DSPC_IDLE);
        SW.hot_swap(1);
        repeat (3) @(negedge ref_clk);
        chk_bits("flagged", 16'h0, {15'h0, flagged});
        rd_chk(10'h000, 8'h2f);
        mod_diag_active[3] = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk_bits("flagged", 16'h1, {15'h0, flagged});
        mod_diag_active[3] = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk_bits("flagged", 16'h0, {15'h0, flagged});
    endtask : t_stuck
    // byte map edges
    task automatic t_map;
        logic [9:0] a[5] = '{10'h001, 10'h003, 10'h004, 10'h230, 10'h231};
        logic [7:0] e[5] = '{8'h22, 8'h44, 8'h5a, 8'h5a, 8'h00};
        foreach (a[i]) rd_chk(a[i], e[i]);
        detail_rd_data = 8'hc3;
        rd_chk(10'h12c, 8'hc3);
    endtask : t_map
    // link states per port, then a traffic blink
    task automatic t_leds;
        logic [1:0] up[3] = '{2'b00, 2'b11, 2'b11};
        logic [1:0] fast[3] = '{2'b11, 2'b01, 2'b11};
        foreach (up[i])
        begin
            @(negedge ref_clk);
            link_up = up[i];
            link_100 = fast[i];
            repeat (5) @(negedge ref_clk);
            chk_bits("led_y", {14'h0, up[i]}, {14'h0, led_y});
            chk_bits("led_g", {14'h0, up[i] & fast[i]}, {14'h0, led_g});
        end
        @(negedge ref_clk);
        frame_evt[0] = 1'b1;
        @(negedge ref_clk);
        frame_evt[0] = 1'b0;
        repeat (5) @(negedge ref_clk);
        chk_bits("led_y", 16'h2, {14'h0, led_y});
        repeat (55 * MSC) @(negedge ref_clk);
        chk_bits("led_y", 16'h3, {14'h0, led_y});
    endtask : t_leds

    // main sequence
    initial
    begin
        repeat (4) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_ignore();
        t_short();
        t_long();
        t_module();
        t_twice();
        t_stuck();
        t_map();
        t_leds();
        close_out();
    end
endmodule : dspc_diag_switch_ctrl_tb
